//--- verilog/module_config_parameter_store.sv
/*
 * Binary command interpreter and parameter store of a serial radio module.
 * Assumes a UART receiver that presents one byte per rxValid pulse, a transmitter
 * that takes bytes on txValid while txReady is high, and synchronous inputs.
 */
`include "mcps_defines.svh"
`default_nettype none
module module_config_parameter_store
   import mcps_pkg::*;
#(
   parameter int TICK_CYCLES = `TICK_CYCLES,
   parameter int PARAM_WAIT_CYCLES = `PARAM_WAIT_CYCLES,
   parameter logic [15:0] FW_VERSION = 16'h1234
)(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic rxValid,
   input wire logic [7:0] rxByte,
   input wire logic cmdPin,
   input wire logic txReady,
   input wire logic [7:0] rssiLevel,
   input wire logic [15:0] serialHigh,
   input wire logic [15:0] serialLow,
   output logic txValid,
   output logic [7:0] txByte,
   output logic ctsN,
   output logic cmdModeActive,
   output logic [15:0] appliedRate,
   output logic [15:0] uartDivisor,
   output mcps_cfg_t cfgOut
);
   // FW_VERSION default is an arbitrary value.

   // Registered state and its next value.
   mcps_state_t stateFf;
   mcps_state_t nxtState;

   // Factory values of every stored parameter.
   function automatic mcps_cfg_t cfgDefaults();
      mcps_cfg_t c;
      c = '0;
      c.timeBeforeSleep = `RST_SLEEP_TIME;
      c.guardTimeAfter = `RST_GUARD_AFTER;
      c.streamLengthLimit = `RST_STREAM_LIMIT;
      c.pendingRate = `RST_IF_RATE;
      c.escapeSequenceChar = `RST_ESCAPE_CHAR;
      return c;
   endfunction

   // Rounded quotient of the divisor base by a nonzero value.
   function automatic logic [31:0] roundDiv(input logic [31:0] den);
      logic [31:0] q;
      q = (32'(`RATE_DIV_BASE) + (den >> 1)) / den;
      return q;
   endfunction

   // Divisor that the UART uses for a stored rate value.
   function automatic logic [15:0] rateDivisor(input logic [15:0] rate);
      logic [15:0] d;
      logic [31:0] q;
      // The rounded quotient is formed first, since a call cannot be sliced directly.
      q = roundDiv({16'h0000, rate});
      unique case (rate)
         16'h0000: d = `DIV_1200;
         16'h0001: d = `DIV_2400;
         16'h0002: d = `DIV_4800;
         16'h0003: d = `DIV_9600;
         16'h0004: d = `DIV_19200;
         16'h0005: d = `DIV_38400;
         16'h0006: d = `DIV_57600;
         default: d = q[15:0];
      endcase
      if (d == 16'h0000) begin
         d = 16'h0001;
      end
      return d;
   endfunction

   // Rate value that is stored for a written rate.
   function automatic logic [15:0] snapRate(input logic [15:0] rate);
      logic [15:0] r;
      logic [31:0] q;
      // The rate that the rounded divisor really produces.
      q = roundDiv({16'h0000, rateDivisor(rate)});
      if (rate <= `MAX_STD_RATE) begin
         r = rate;
      end else begin
         r = q[15:0];
      end
      return r;
   endfunction

   // Value of a parameter as the host reads it; narrow values sit in the low byte.
   function automatic logic [15:0] readParam(input mcps_cfg_t c, input logic [7:0] code,
                                             input logic [7:0] rssi, input logic [15:0] snHi,
                                             input logic [15:0] snLo);
      logic [15:0] v;
      logic [7:0] s;
      s = rssi;
      if (s < `MIN_RSSI) begin
         s = `MIN_RSSI;
      end else if (s > `MAX_RSSI) begin
         s = `MAX_RSSI;
      end
      unique case (code)
         `CMD_SLEEP_MODE: v = {8'h00, c.sleepModeSelect};
         `CMD_SLEEP_TIME: v = c.timeBeforeSleep;
         `CMD_GUARD_AFTER: v = c.guardTimeAfter;
         `CMD_FW_VERSION: v = FW_VERSION;
         `CMD_IF_RATE: v = c.pendingRate;
         `CMD_SECOND_IN: v = {8'h00, c.secondInputConfig};
         `CMD_INIT_TIME: v = {8'h00, c.timeBeforeInit};
         `CMD_RETRIES: v = {8'h00, c.retryCount};
         `CMD_DELAY_SLOTS: v = {8'h00, c.delaySlotCount};
         `CMD_STREAM_LIMIT: v = c.streamLengthLimit;
         `CMD_TX_ERRORS: v = c.transmitErrorCounter;
         `CMD_RSSI: v = {8'h00, s};
         `CMD_PIN_WAKE: v = {8'h00, c.pinWakeupEnable};
         `CMD_POWERUP: v = {8'h00, c.powerupModeSelect};
         `CMD_PKT_TIMEOUT: v = c.packetTimeout;
         `CMD_PWM_TIMER: v = {8'h00, c.strengthPwmTimer};
         `CMD_PARITY: v = {8'h00, c.paritySelect};
         `CMD_SERIAL_HI: v = snHi;
         `CMD_SERIAL_LO: v = snLo;
         `CMD_STOP_BITS: v = {8'h00, c.stopBitSelect};
         default: v = 16'h0000;
      endcase
      return v;
   endfunction

   // Stores a written value, clamped into its range; read-only codes are ignored.
   function automatic mcps_cfg_t writeParam(input mcps_cfg_t c, input logic [7:0] code,
                                            input logic [15:0] v);
      mcps_cfg_t n;
      n = c;
      unique case (code)
         `CMD_SLEEP_MODE: n.sleepModeSelect = v[7:0];
         `CMD_SLEEP_TIME: n.timeBeforeSleep = (v < `MIN_SLEEP_TIME) ? `MIN_SLEEP_TIME : v;
         `CMD_GUARD_AFTER: n.guardTimeAfter = (v < `MIN_GUARD_AFTER) ? `MIN_GUARD_AFTER : v;
         `CMD_IF_RATE: n.pendingRate = snapRate(v);
         `CMD_SECOND_IN: n.secondInputConfig = v[7:0];
         `CMD_INIT_TIME: n.timeBeforeInit = v[7:0];
         `CMD_RETRIES: n.retryCount = v[7:0];
         `CMD_DELAY_SLOTS: n.delaySlotCount = v[7:0];
         `CMD_STREAM_LIMIT: n.streamLengthLimit = v;
         `CMD_TX_ERRORS: n.transmitErrorCounter = v;
         `CMD_PIN_WAKE: n.pinWakeupEnable = v[7:0];
         `CMD_POWERUP: n.powerupModeSelect = v[7:0];
         `CMD_PKT_TIMEOUT: n.packetTimeout = v;
         `CMD_PWM_TIMER: n.strengthPwmTimer = (v > {8'h00, `MAX_PWM_TIMER}) ? `MAX_PWM_TIMER : v[7:0];
         `CMD_PARITY: n.paritySelect = v[7:0];
         `CMD_STOP_BITS: n.stopBitSelect = v[7:0];
         default: n = c;
      endcase
      return n;
   endfunction

   // True for codes that act at once; others carry a value.
   function automatic logic isAction(input logic [7:0] code);
      return (code == `CMD_EXIT) || (code == `CMD_RESTORE) || (code == `CMD_WRITE);
   endfunction

   // Next-state logic of the guard timer and the command interpreter.
   always_comb begin
      nxtState = stateFf;
      nxtState.txValid = stateFf.txValid && !txReady;
      // Guard timer: an escape character on the data path arms or restarts it outside command mode; any other data byte disarms it.
      if (rxValid && !cmdPin) begin
         nxtState.guardArmed = !stateFf.cmdModeActive && (rxByte == stateFf.cfg.escapeSequenceChar);
         nxtState.tickCnt = 20'h0_0000;
         nxtState.unitCnt = 16'h0000;
      end else if (stateFf.guardArmed) begin
         if (stateFf.tickCnt == 20'(TICK_CYCLES - 1)) begin
            nxtState.tickCnt = 20'h0_0000;
            nxtState.unitCnt = stateFf.unitCnt + 16'h0001;
            // Enough silent units seen: enter command mode.
            if (stateFf.unitCnt + 16'h0001 >= stateFf.cfg.guardTimeAfter) begin
               nxtState.cmdModeActive = 1'b1;
               nxtState.guardArmed = 1'b0;
            end
         end else begin
            nxtState.tickCnt = stateFf.tickCnt + 20'h0_0001;
         end
      end
      // Binary command interpreter.
      unique case (stateFf.cmdState)
         CmdIdle: begin
            if (rxValid && cmdPin) begin
               nxtState.cmdCode = rxByte;
               nxtState.waitCnt = 16'h0000;
               if (rxByte == `CMD_EXIT) begin
                  // Leaving command mode is the moment the new rate takes effect.
                  nxtState.cmdModeActive = 1'b0;
                  nxtState.appliedRate = stateFf.cfg.pendingRate;
                  nxtState.uartDivisor = rateDivisor(stateFf.cfg.pendingRate);
               end else if (rxByte == `CMD_RESTORE) begin
                  nxtState.cfg = cfgDefaults();
               end
               if (!isAction(rxByte)) begin
                  nxtState.cmdState = CmdParamLo;
               end
            end
         end
         CmdParamLo: begin
            if (rxValid && cmdPin) begin
               nxtState.paramLo = rxByte;
               nxtState.waitCnt = 16'h0000;
               nxtState.cmdState = CmdParamHi;
            end else if (stateFf.waitCnt == 16'(PARAM_WAIT_CYCLES - 1)) begin
               // No value followed the code: answer with the stored value.
               nxtState.respWord = readParam(stateFf.cfg, stateFf.cmdCode, rssiLevel,
                                             serialHigh, serialLow);
               nxtState.cmdState = CmdRespLo;
            end else begin
               nxtState.waitCnt = stateFf.waitCnt + 16'h0001;
            end
         end
         CmdParamHi: begin
            if (rxValid && cmdPin) begin
               nxtState.cfg = writeParam(stateFf.cfg, stateFf.cmdCode, {rxByte, stateFf.paramLo});
               nxtState.cmdState = CmdIdle;
            end else if (stateFf.waitCnt == 16'(PARAM_WAIT_CYCLES - 1)) begin
               // A lone low byte is dropped.
               nxtState.cmdState = CmdIdle;
            end else begin
               nxtState.waitCnt = stateFf.waitCnt + 16'h0001;
            end
         end
         CmdRespLo: begin
            if (!stateFf.txValid || txReady) begin
               nxtState.txValid = 1'b1;
               nxtState.txByte = stateFf.respWord[7:0];
               nxtState.cmdState = CmdRespHi;
            end
         end
         CmdRespHi: begin
            if (txReady) begin
               nxtState.txValid = 1'b1;
               nxtState.txByte = stateFf.respWord[15:8];
               nxtState.cmdState = CmdIdle;
            end
         end
      endcase
      // Clear-to-send is held off while a command is in progress.
      nxtState.ctsN = (nxtState.cmdState != CmdIdle);
   end

   // State register with synchronous reset.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         stateFf <= '0;
         stateFf.cfg <= cfgDefaults();
         stateFf.cmdState <= CmdIdle;
         stateFf.appliedRate <= `RST_IF_RATE;
         stateFf.uartDivisor <= `DIV_9600;
      end else begin
         stateFf <= nxtState;
      end
   end

   // Outputs come straight from the state register.
   assign txValid = stateFf.txValid;
   assign txByte = stateFf.txByte;
   assign ctsN = stateFf.ctsN;
   assign cmdModeActive = stateFf.cmdModeActive;
   assign appliedRate = stateFf.appliedRate;
   assign uartDivisor = stateFf.uartDivisor;
   assign cfgOut = stateFf.cfg;
endmodule
`default_nettype wire

//--- verilog/mcps_defines.svh
/*
 * Constants of the parameter store: command codes, reset values, ranges and timing.
 * Assumes a 10 MHz module clock and a UART that oversamples by sixteen.
 */
`ifndef MCPS_DEFINES_SVH
`define MCPS_DEFINES_SVH
// Command codes of the stored parameters and of the actions.
`define CMD_SLEEP_MODE 8'h01
`define CMD_SLEEP_TIME 8'h02
`define CMD_GUARD_AFTER 8'h05
`define CMD_WRITE 8'h08
`define CMD_EXIT 8'h09
`define CMD_RESTORE 8'h0E
`define CMD_FW_VERSION 8'h14
`define CMD_IF_RATE 8'h15
`define CMD_SECOND_IN 8'h16
`define CMD_INIT_TIME 8'h17
`define CMD_RETRIES 8'h18
`define CMD_DELAY_SLOTS 8'h19
`define CMD_STREAM_LIMIT 8'h1A
`define CMD_TX_ERRORS 8'h1B
`define CMD_RSSI 8'h1C
`define CMD_PIN_WAKE 8'h1D
`define CMD_POWERUP 8'h1E
`define CMD_PKT_TIMEOUT 8'h21
`define CMD_PWM_TIMER 8'h22
`define CMD_PARITY 8'h23
`define CMD_SERIAL_HI 8'h25
`define CMD_SERIAL_LO 8'h26
`define CMD_STOP_BITS 8'h36
// Reset values.
`define RST_SLEEP_TIME 16'h0064
`define RST_GUARD_AFTER 16'h000A
`define RST_STREAM_LIMIT 16'hFFFF
`define RST_IF_RATE 16'h0003
`define RST_ESCAPE_CHAR 8'h2B
// Range limits.
`define MIN_GUARD_AFTER 16'h0002
`define MIN_SLEEP_TIME 16'h0010
`define MAX_PWM_TIMER 8'h7F
`define MIN_RSSI 8'h06
`define MAX_RSSI 8'h36
`define MAX_STD_RATE 16'h0006
// Timing.
`define CLK_HZ 10000000
`define GUARD_UNIT_MS 100
`define PARAM_WAIT_MS 1
`define TICK_CYCLES (`GUARD_UNIT_MS * (`CLK_HZ / 1000))
`define PARAM_WAIT_CYCLES (`PARAM_WAIT_MS * (`CLK_HZ / 1000))
// UART divisor base and divisors of the seven standard rates.
`define RATE_DIV_BASE (`CLK_HZ / 16)
`define DIV_1200 16'd521
`define DIV_2400 16'd260
`define DIV_4800 16'd130
`define DIV_9600 16'd65
`define DIV_19200 16'd33
`define DIV_38400 16'd16
`define DIV_57600 16'd11
`endif

//--- verilog/mcps_pkg.sv
/*
 * Types of the parameter store: command state, stored configuration and full state.
 * Assumes mcps_defines.svh is compiled alongside.
 */
`default_nettype none
package mcps_pkg;
   // Command interpreter states.
   typedef enum logic [2:0] {CmdIdle, CmdParamLo, CmdParamHi, CmdRespLo, CmdRespHi} mcps_cmd_state_t;
   // Software-visible stored parameters.
   typedef struct packed {
      logic [7:0] sleepModeSelect;
      logic [15:0] timeBeforeSleep;
      logic [15:0] guardTimeAfter;
      logic [15:0] pendingRate;
      logic [7:0] secondInputConfig;
      logic [7:0] timeBeforeInit;
      logic [7:0] retryCount;
      logic [7:0] delaySlotCount;
      logic [15:0] streamLengthLimit;
      logic [15:0] transmitErrorCounter;
      logic [7:0] pinWakeupEnable;
      logic [7:0] powerupModeSelect;
      logic [15:0] packetTimeout;
      logic [7:0] strengthPwmTimer;
      logic [7:0] paritySelect;
      logic [7:0] stopBitSelect;
      logic [7:0] escapeSequenceChar;
   } mcps_cfg_t;
   // Whole state of the block.
   typedef struct packed {
      mcps_cfg_t cfg;
      mcps_cmd_state_t cmdState;
      logic [7:0] cmdCode;
      logic [7:0] paramLo;
      logic [15:0] respWord;
      logic [15:0] waitCnt;
      logic guardArmed;
      logic [19:0] tickCnt;
      logic [15:0] unitCnt;
      logic cmdModeActive;
      logic ctsN;
      logic txValid;
      logic [7:0] txByte;
      logic [15:0] appliedRate;
      logic [15:0] uartDivisor;
   } mcps_state_t;
endpackage
`default_nettype wire

//--- test/mcps_chk.sv
/* Concurrent checks on the ports of the parameter store.
   Assumes it is bound into module_config_parameter_store and sees its ports only. */
`default_nettype none
module mcps_chk
   import mcps_pkg::*;
#(
   parameter int TICK_CYCLES = 10,
   parameter int PARAM_WAIT_CYCLES = 8
)(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic rxValid,
   input wire logic [7:0] rxByte,
   input wire logic cmdPin,
   input wire logic txReady,
   input wire logic txValid,
   input wire logic [7:0] txByte,
   input wire logic ctsN,
   input wire logic cmdModeActive,
   input wire logic [15:0] appliedRate,
   input wire logic [15:0] uartDivisor,
   input wire mcps_cfg_t cfgOut
);
   timeunit 1ns;
   timeprecision 1ns;
   // A byte taken as a command code while the interpreter is idle.
   logic codeIn;
   // Silent cycles on the serial input since the last byte.
   logic [31:0] quietCnt;
   assign codeIn = rxValid && cmdPin && !ctsN;
   // The silence counter restarts on every received byte.
   always_ff @(posedge clk) begin
      if (!rst_n || rxValid) begin
         quietCnt <= 32'h0;
      end else begin
         quietCnt <= quietCnt + 32'h1;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // A code that opens a parameter exchange, a quiet value slot, and the exit code.
   sequence sCode; codeIn && !(rxByte inside {8'h08, 8'h09, 8'h0E}); endsequence
   sequence sSilent; !rxValid [*8]; endsequence
   sequence sExit; codeIn && rxByte == 8'h09; endsequence
   cts_on_code_a: assert property (sCode |=> ctsN) else $error("cts not raised after code");
   read_answer_a: assert property (sCode ##1 sSilent |=> ##1 txValid) else $error("no answer after quiet slot");
   read_no_early_a: assert property (sCode |=> !txValid [*8]) else $error("answer came early");
   exit_applies_a: assert property (sExit |=> !cmdModeActive && appliedRate == $past(cfgOut.pendingRate))
      else $error("exit did not apply rate");
   rate_held_a: assert property (!(codeIn && rxByte inside {8'h09, 8'h0E}) |=> $stable(appliedRate))
      else $error("rate changed without exit");
   div_follows_a: assert property (!$stable(uartDivisor) |-> !$stable(appliedRate))
      else $error("divisor moved alone");
   tx_hold_a: assert property (txValid && !txReady |=> txValid && $stable(txByte)) else $error("byte dropped");
   guard_quiet_a: assert property ($rose(cmdModeActive) |-> quietCnt >= cfgOut.guardTimeAfter * TICK_CYCLES)
      else $error("command mode without silence");
   guard_floor_a: assert property (cfgOut.guardTimeAfter >= 16'h0002) else $error("guard below floor");
   pwm_cap_a: assert property (cfgOut.strengthPwmTimer <= 8'h7F) else $error("pwm timer above cap");
   sleep_floor_a: assert property (cfgOut.timeBeforeSleep >= 16'h0010) else $error("sleep time below floor");
endmodule
bind module_config_parameter_store mcps_chk #(.TICK_CYCLES(TICK_CYCLES), .PARAM_WAIT_CYCLES(PARAM_WAIT_CYCLES)) chk (
   .clk(clk), .rst_n(rst_n), .rxValid(rxValid), .rxByte(rxByte), .cmdPin(cmdPin), .txReady(txReady),
   .txValid(txValid), .txByte(txByte), .ctsN(ctsN), .cmdModeActive(cmdModeActive),
   .appliedRate(appliedRate), .uartDivisor(uartDivisor), .cfgOut(cfgOut));
`default_nettype wire

//--- test/mcps_host_model.sv
/* Host receive side: takes response bytes and pairs them into words.
   Assumes the store holds txValid and txByte until it sees txReady high. */
`default_nettype none
module mcps_host_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic txValid,
   input wire logic [7:0] txByte,
   input wire logic slow,
   output logic txReady,
   output logic [15:0] word,
   output logic wordDone
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [2:0] stall; // Cycles left before the host is ready again.
   logic half; // High once the low byte is in.
   logic [7:0] lo; // Low byte of the word being built.
   // After each byte the host drops ready; a slow host waits longer, which exercises holding.
   always_ff @(posedge clk) begin
      wordDone <= 1'b0;
      if (!rst_n) begin
         txReady <= 1'b0;
         stall <= 3'h0;
         half <= 1'b0;
      end else if (txValid && txReady) begin
         txReady <= 1'b0;
         stall <= slow ? 3'h5 : 3'h0;
         half <= !half;
         if (half) begin
            word <= {txByte, lo};
            wordDone <= 1'b1;
         end else begin
            lo <= txByte;
         end
      end else if (stall != 3'h0) begin
         stall <= stall - 3'h1;
      end else begin
         txReady <= 1'b1;
      end
   end
endmodule
`default_nettype wire

//--- test/mcps_tb.sv
/* Self-checking bench of the parameter store, driving binary commands byte by byte.
   Assumes short tick and wait counts and the host model on the response side. */
`include "mcps_defines.svh"
`default_nettype none
module tb
   import mcps_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rst_n, rxValid, cmdPin, slow, txReady, txValid, ctsN, cmdModeActive, wordDone;
   logic [7:0] rxByte, rssiLevel, txByte;
   logic [15:0] serialHigh, serialLow, appliedRate, uartDivisor, word, got;
   mcps_cfg_t cfgOut;
   int bad_count = 0, num_checks = 0, cycles = 0;
   // Defaults read after reset, code 16 after a write of 1, then writes with the value expected back.
   logic [7:0] dCode [8] = '{8'h02, 8'h05, 8'h1A, 8'h22, 8'h17, 8'h21, 8'h15, 8'h16};
   logic [15:0] dExp [8] = '{16'h0064, 16'h000A, 16'hFFFF, 16'h0000, 16'h0000, 16'h0000, 16'h0003, 16'h0001};
   logic [7:0] wCode [9] = '{8'h1A, 8'h21, 8'h17, 8'h22, 8'h02, 8'h05, 8'h1C, 8'h25, 8'h26};
   logic [15:0] wVal [9] = '{16'h0000, 16'hFFFF, 16'h00FF, 16'h0080, 16'h000F, 16'h0001, 16'h1111, 16'h1111, 16'hFFFF};
   logic [15:0] wExp [9] = '{16'h0000, 16'hFFFF, 16'h00FF, 16'h007F, 16'h0010, 16'h0002, 16'h0036, 16'hA5C3, 16'h0000};
   logic [15:0] divTab [7] = '{`DIV_1200, `DIV_2400, `DIV_4800, `DIV_9600, `DIV_19200, `DIV_38400, `DIV_57600};
   module_config_parameter_store #(.TICK_CYCLES(10), .PARAM_WAIT_CYCLES(8)) dut (
      .clk(clk), .rst_n(rst_n), .rxValid(rxValid), .rxByte(rxByte), .cmdPin(cmdPin), .txReady(txReady),
      .rssiLevel(rssiLevel), .serialHigh(serialHigh), .serialLow(serialLow), .txValid(txValid),
      .txByte(txByte), .ctsN(ctsN), .cmdModeActive(cmdModeActive), .appliedRate(appliedRate),
      .uartDivisor(uartDivisor), .cfgOut(cfgOut));
   mcps_host_model host (.clk(clk), .rst_n(rst_n), .txValid(txValid), .txByte(txByte), .slow(slow),
      .txReady(txReady), .word(word), .wordDone(wordDone));
   // Free-running 10 MHz clock.
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // Prints the counts and the verdict, then stops.
   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // Compares one value and counts it.
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      num_checks++;
      if (g !== e) begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // One received byte, a one-cycle strobe.
   task automatic sendByte(input logic [7:0] b, input logic pin);
      @(posedge clk);
      rxValid <= 1'b1;
      rxByte <= b;
      cmdPin <= pin;
      @(posedge clk);
      rxValid <= 1'b0;
   endtask
   // Code, low byte, high byte, then a pause for the store to go idle.
   task automatic wr(input logic [7:0] c, input logic [15:0] v);
      sendByte(c, 1'b1);
      sendByte(v[7:0], 1'b1);
      sendByte(v[15:8], 1'b1);
      repeat (3) @(posedge clk);
   endtask
   // A code with no value must answer with the stored word.
   task automatic rdChk(input logic [7:0] c, input logic [15:0] e);
      int n;
      n = 0;
      sendByte(c, 1'b1);
      #1;
      chk({15'h0, ctsN}, 16'h0001);
      while (wordDone !== 1'b1 && n < 200) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk(word, e);
      repeat (2) @(posedge clk);
   endtask
   // A hang counts as a mismatch and ends the run.
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         bad_count++;
         summarize();
      end
   end
   // Main sequence of tests.
   initial begin
      rst_n = 1'b0;
      rxValid = 1'b0;
      rxByte = 8'h00;
      cmdPin = 1'b0;
      slow = 1'b0;
      rssiLevel = 8'h40;
      serialHigh = 16'hA5C3;
      serialLow = 16'h0000;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      wr(8'h16, 16'h0001);
      for (int i = 0; i < 8; i++) rdChk(dCode[i], dExp[i]);
      $display("test defaults done");
      slow <= 1'b1;
      for (int i = 0; i < 9; i++) begin
         wr(wCode[i], wVal[i]);
         rdChk(wCode[i], wExp[i]);
      end
      rssiLevel <= 8'h03;
      rdChk(8'h1C, 16'h0006);
      slow <= 1'b0;
      $display("test write and read-only done");
      for (int i = 0; i < 7; i++) begin
         wr(8'h15, i[15:0]);
         chk(appliedRate, (i == 0) ? 16'h0003 : i[15:0] - 16'h1);
         sendByte(8'h09, 1'b1);
         @(posedge clk);
         #1;
         chk(appliedRate, i[15:0]);
         chk(uartDivisor, divTab[i]);
      end
      wr(8'h15, 16'hEA60);
      rdChk(8'h15, 16'hF424);
      sendByte(8'h09, 1'b1);
      @(posedge clk);
      #1;
      chk(uartDivisor, 16'h000A);
      $display("test interface rate done");
      sendByte(8'h2B, 1'b0);
      repeat (8) @(posedge clk);
      sendByte(8'h41, 1'b0);
      repeat (40) @(posedge clk);
      #1;
      chk({15'h0, cmdModeActive}, 16'h0000);
      sendByte(8'h2B, 1'b0);
      repeat (18) @(posedge clk);
      #1;
      chk({15'h0, cmdModeActive}, 16'h0000);
      repeat (6) @(posedge clk);
      #1;
      chk({15'h0, cmdModeActive}, 16'h0001);
      sendByte(8'h09, 1'b1);
      @(posedge clk);
      #1;
      chk({15'h0, cmdModeActive}, 16'h0000);
      $display("test guard time done");
      sendByte(8'h0E, 1'b1);
      rdChk(8'h05, 16'h000A);
      $display("test restore done");
      summarize();
   end
endmodule
`default_nettype wire
